// File: common/hrw_pkg.sv
//------------------------------------------------------------
// hibernation rtc wake controller package
//------------------------------------------------------------
// What this block does
// - only control writes and register reads work until software sets the module enable bit.
// - clock source is raw 32.768 kHz tick or crystal tick divided by 128.
// - a 32-bit real-time counter is kept.
// - counter started and stopped by separate enable and disable writes.
// - counter value is readable and loadable by software.
// - two readable writable match values, each raising a counter event.
// - readable writable trim fine-tunes the counter advance rate.
// - 64 retained 32-bit words, readable and writable.
// - wake on pin, on match, or both; configuration reads back.
// - after power removal, a configured wake restores processor power.
// - low battery is detected and reported to the processor.
// - optional abort of hibernation request on low battery, readable.
// - a software hibernation request starts the power removal sequence.
// - active state survives power loss and reads after power-on reset.
// - latched interrupt flags stay readable after wake.
// - each source has its own enable and disable; status readable.
// - four sources: wake pin, low battery, match zero, match one.
// - status reads raw or masked by enables.
// - flags stay set until software clears them.
package hrw_pkg;
    // register word addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_RTC_ON   = 8'h01;
    localparam logic [7:0] ADDR_RTC_OFF  = 8'h02;
    localparam logic [7:0] ADDR_RTC_LOAD = 8'h03;
    localparam logic [7:0] ADDR_MATCH0   = 8'h04;
    localparam logic [7:0] ADDR_MATCH1   = 8'h05;
    localparam logic [7:0] ADDR_TRIM     = 8'h06;
    localparam logic [7:0] ADDR_INT_EN   = 8'h07;
    localparam logic [7:0] ADDR_INT_DIS  = 8'h08;
    localparam logic [7:0] ADDR_RAW      = 8'h09;
    localparam logic [7:0] ADDR_MASKED   = 8'h0a;
    localparam logic [7:0] ADDR_INT_CLR  = 8'h0b;
    localparam logic [7:0] ADDR_REQUEST  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS   = 8'h0d;
    localparam logic [7:0] ADDR_MEM_BASE = 8'h40;
    // control register fields
    localparam int CTRL_ENABLE   = 0;
    localparam int CTRL_CLK_DIV  = 1;
    localparam int CTRL_WAKE_PIN = 2;
    localparam int CTRL_WAKE_RTC = 3;
    localparam int CTRL_BAT_ABRT = 4;
    localparam int CTRL_W        = 5;
    // interrupt bit positions
    localparam int IRQ_PIN_WAKE  = 0;
    localparam int IRQ_BAT_LOW   = 1;
    localparam int IRQ_MATCH0    = 2;
    localparam int IRQ_MATCH1    = 3;
    localparam int IRQ_W         = 4;
    // reset values and timing
    localparam logic [15:0] TRIM_RESET  = 16'h7fff;
    localparam logic [6:0]  XTAL_DIV_M1 = 7'h7f;   // divide by 128
    localparam logic [4:0]  CTRL_RESET  = 5'h00;
endpackage

// File: rtl/hrw_top.sv
`timescale 1ns/10ps
module hrw_top (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // external pins and sense inputs
    input  wire logic        osc_tick,
    input  wire logic        xtal_tick,
    input  wire logic        wake_pin,
    input  wire logic        battery_low,
    // power control and interrupt
    output logic             proc_power_on,
    output logic             battery_low_irq,
    output logic             irq
);
    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_ON   = 2'b00,
        PWR_DOWN = 2'b01,
        PWR_OFF  = 2'b10
    } hrw_pwr_type;

    typedef struct packed {
        logic [4:0]  ctrl;
        logic        rtc_run;
        logic [31:0] rtc;
        logic [31:0] match0;
        logic [31:0] match1;
        logic [15:0] trim;
        logic [15:0] sub;
        logic [6:0]  div;
        logic [3:0]  irq_en;
        logic [3:0]  irq_raw;
        hrw_pwr_type pwr;
        logic [2:0]  osc_s;
        logic [2:0]  xtal_s;
        logic [1:0]  wake_s;
        logic [1:0]  bat_s;
        logic        wake_prev;
        logic        bat_prev;
        logic [31:0] rdata;
        logic        irq;
        logic        pwr_on;
    } hrw_state_type;

    hrw_state_type s_q;
    hrw_state_type s_d;

    // retained storage, no reset so contents survive
    logic [31:0] mem_q [0:63];

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] b);
        hit = (a == b);
    endfunction

    //------------------------------------------------------------
    // next-state logic
    //------------------------------------------------------------
    logic        en;
    logic        tick;
    logic        adv;
    logic [16:0] acc;
    logic [3:0]  ev;
    logic [31:0] rtc_nx;
    logic        wr_mem;
    logic [3:0]  masked;

    always_comb begin
        s_d    = s_q;
        en     = s_q.ctrl[hrw_pkg::CTRL_ENABLE];
        ev     = 4'h0;
        adv    = 1'b0;
        acc    = 17'h00000;
        rtc_nx = s_q.rtc;
        wr_mem = reg_wr && (reg_addr[7:6] == 2'b01);
        // synchronisers, third stage only for edge detect
        s_d.osc_s  = {s_q.osc_s[1:0], osc_tick};
        s_d.xtal_s = {s_q.xtal_s[1:0], xtal_tick};
        s_d.wake_s = {s_q.wake_s[0], wake_pin};
        s_d.bat_s  = {s_q.bat_s[0], battery_low};
        s_d.wake_prev = s_q.wake_s[1];
        s_d.bat_prev  = s_q.bat_s[1];
        // clock source select
        tick = 1'b0;
        if (s_q.ctrl[hrw_pkg::CTRL_CLK_DIV]) begin
            if (s_q.xtal_s[1] && !s_q.xtal_s[2]) begin
                s_d.div = s_q.div + 7'h01;
                tick = (s_q.div == hrw_pkg::XTAL_DIV_M1);
            end
        end else begin
            tick = s_q.osc_s[1] && !s_q.osc_s[2];
        end
        // trim: fractional accumulator, (trim+1)/0x8000 per tick for trim up to 0x7fff, one per tick above
        if (en && s_q.rtc_run && tick) begin
            acc   = {1'b0, s_q.sub} + {1'b0, s_q.trim} + 17'h00001;
            adv   = acc[16] | acc[15];
            s_d.sub = {1'b0, acc[14:0]};
            if (acc[16] && acc[15]) begin
                rtc_nx = s_q.rtc + 32'h00000002;
            end else if (adv) begin
                rtc_nx = s_q.rtc + 32'h00000001;
            end
        end
        s_d.rtc = rtc_nx;
        // match events on counter change
        if (adv && rtc_nx == s_q.match0) begin
            ev[hrw_pkg::IRQ_MATCH0] = 1'b1;
        end
        if (adv && rtc_nx == s_q.match1) begin
            ev[hrw_pkg::IRQ_MATCH1] = 1'b1;
        end
        if (en && s_q.wake_s[1] && !s_q.wake_prev) begin
            ev[hrw_pkg::IRQ_PIN_WAKE] = 1'b1;
        end
        if (en && s_q.bat_s[1] && !s_q.bat_prev) begin
            ev[hrw_pkg::IRQ_BAT_LOW] = 1'b1;
        end
        // register writes
        s_d.rdata = 32'h00000000;
        if (reg_wr) begin
            if (hit(reg_addr, hrw_pkg::ADDR_CTRL)) begin
                s_d.ctrl = reg_wdata[hrw_pkg::CTRL_W-1:0];
            end
            if (en) begin
                if (hit(reg_addr, hrw_pkg::ADDR_RTC_ON)) begin
                    s_d.rtc_run = 1'b1;
                end
                if (hit(reg_addr, hrw_pkg::ADDR_RTC_OFF)) begin
                    s_d.rtc_run = 1'b0;
                end
                if (hit(reg_addr, hrw_pkg::ADDR_RTC_LOAD)) begin
                    s_d.rtc = reg_wdata;
                    s_d.sub = 16'h0000;
                end
                if (hit(reg_addr, hrw_pkg::ADDR_MATCH0)) begin
                    s_d.match0 = reg_wdata;
                end
                if (hit(reg_addr, hrw_pkg::ADDR_MATCH1)) begin
                    s_d.match1 = reg_wdata;
                end
                if (hit(reg_addr, hrw_pkg::ADDR_TRIM)) begin
                    s_d.trim = reg_wdata[15:0];
                end
                if (hit(reg_addr, hrw_pkg::ADDR_INT_EN)) begin
                    s_d.irq_en = s_q.irq_en | reg_wdata[3:0];
                end
                if (hit(reg_addr, hrw_pkg::ADDR_INT_DIS)) begin
                    s_d.irq_en = s_q.irq_en & ~reg_wdata[3:0];
                end
                if (hit(reg_addr, hrw_pkg::ADDR_REQUEST)
                    && s_q.pwr == PWR_ON) begin
                    if (!(s_q.ctrl[hrw_pkg::CTRL_BAT_ABRT]
                          && s_q.bat_s[1])) begin
                        s_d.pwr = PWR_DOWN;
                    end
                end
            end
        end
        // flags: set beats clear
        s_d.irq_raw = s_q.irq_raw;
        if (reg_wr && en && hit(reg_addr, hrw_pkg::ADDR_INT_CLR)) begin
            s_d.irq_raw = s_q.irq_raw & ~reg_wdata[3:0];
        end
        s_d.irq_raw = s_d.irq_raw | ev;
        // power sequence
        unique case (s_q.pwr)
            PWR_ON: begin
            end
            PWR_DOWN: begin
                s_d.pwr = PWR_OFF;
            end
            PWR_OFF: begin
                if ((s_q.ctrl[hrw_pkg::CTRL_WAKE_PIN]
                     && ev[hrw_pkg::IRQ_PIN_WAKE])
                    || (s_q.ctrl[hrw_pkg::CTRL_WAKE_RTC]
                        && |ev[hrw_pkg::IRQ_MATCH1:hrw_pkg::IRQ_MATCH0]))
                begin
                    s_d.pwr = PWR_ON;
                end
            end
            default: begin
                s_d.pwr = PWR_ON;
            end
        endcase
        if (!en) begin
            s_d.pwr = PWR_ON;
        end
        // register reads
        masked = s_q.irq_raw & s_q.irq_en;
        if (reg_rd) begin
            if (reg_addr[7:6] == 2'b01) begin
                s_d.rdata = mem_q[reg_addr[5:0]];
            end else if (hit(reg_addr, hrw_pkg::ADDR_CTRL)) begin
                s_d.rdata = {27'h0000000, s_q.ctrl};
            end else if (hit(reg_addr, hrw_pkg::ADDR_RTC_LOAD)) begin
                s_d.rdata = s_q.rtc;
            end else if (hit(reg_addr, hrw_pkg::ADDR_MATCH0)) begin
                s_d.rdata = s_q.match0;
            end else if (hit(reg_addr, hrw_pkg::ADDR_MATCH1)) begin
                s_d.rdata = s_q.match1;
            end else if (hit(reg_addr, hrw_pkg::ADDR_TRIM)) begin
                s_d.rdata = {16'h0000, s_q.trim};
            end else if (hit(reg_addr, hrw_pkg::ADDR_INT_EN)) begin
                s_d.rdata = {28'h0000000, s_q.irq_en};
            end else if (hit(reg_addr, hrw_pkg::ADDR_RAW)) begin
                s_d.rdata = {28'h0000000, s_q.irq_raw};
            end else if (hit(reg_addr, hrw_pkg::ADDR_MASKED)) begin
                s_d.rdata = {28'h0000000, masked};
            end else if (hit(reg_addr, hrw_pkg::ADDR_STATUS)) begin
                s_d.rdata = {28'h0000000, s_q.bat_s[1], s_q.rtc_run,
                             s_q.pwr};
            end
        end
        s_d.irq = |(s_d.irq_raw & s_d.irq_en);
        // power output registered so the pin comes from a flop
        s_d.pwr_on = (s_d.pwr == PWR_ON);
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q        <= '0;
            s_q.ctrl   <= hrw_pkg::CTRL_RESET;
            s_q.trim   <= hrw_pkg::TRIM_RESET;
            s_q.pwr    <= PWR_ON;
            s_q.pwr_on <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // retained memory write port
    always_ff @(posedge sys_clk) begin
        if (wr_mem && en) begin
            mem_q[reg_addr[5:0]] <= reg_wdata;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    assign reg_rdata       = s_q.rdata;
    assign proc_power_on   = s_q.pwr_on;
    assign battery_low_irq = s_q.irq_raw[hrw_pkg::IRQ_BAT_LOW];
    assign irq             = s_q.irq;
endmodule

// File: verification/hrw_props.sv
`timescale 1ns/10ps
module hrw_props (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // power and interrupts
    input wire logic        proc_power_on,
    input wire logic        battery_low_irq,
    input wire logic        irq
);
    logic [4:0]  ctrl_q;
    logic [15:0] trim_q;
    logic [3:0]  ien_q;
    logic        ok;
    // shadow of control, trim and enables; trim and enable writes refused while disabled
    assign ok = reg_wr && ctrl_q[0];
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= hrw_pkg::CTRL_RESET;
            trim_q <= hrw_pkg::TRIM_RESET;
            ien_q  <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == hrw_pkg::ADDR_CTRL)
                ctrl_q <= reg_wdata[4:0];
            if (ok && reg_addr == hrw_pkg::ADDR_TRIM)
                trim_q <= reg_wdata[15:0];
            if (ok && reg_addr == hrw_pkg::ADDR_INT_EN)
                ien_q <= ien_q | reg_wdata[3:0];
            if (ok && reg_addr == hrw_pkg::ADDR_INT_DIS)
                ien_q <= ien_q & ~reg_wdata[3:0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // request then power removal
    sequence s_req;
        ok && reg_addr == hrw_pkg::ADDR_REQUEST && proc_power_on && !ctrl_q[4];
    endsequence
    sequence s_down;
        ##[1:3] !proc_power_on;
    endsequence
    AST_REQ_DOWN: assert property (s_req |-> s_down)
        else $error("request left power on");
    AST_DIS_PWR: assert property (reg_wr && reg_addr == hrw_pkg::ADDR_CTRL
        && !reg_wdata[0] |-> ##[1:2] proc_power_on)
        else $error("disabled module left power off");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    AST_CTRL_RB: assert property (reg_rd && reg_addr == hrw_pkg::ADDR_CTRL
        |=> reg_rdata[4:0] == ctrl_q) else $error("control readback");
    AST_TRIM_RB: assert property (reg_rd && reg_addr == hrw_pkg::ADDR_TRIM
        |=> reg_rdata[15:0] == trim_q) else $error("trim readback");
    AST_IEN_RB: assert property (reg_rd && reg_addr == hrw_pkg::ADDR_INT_EN
        |=> reg_rdata[3:0] == ien_q) else $error("enable readback");
    AST_MASKED: assert property (reg_rd && reg_addr == hrw_pkg::ADDR_MASKED
        |=> (reg_rdata[3:0] & ~ien_q) == 4'h0) else $error("masked status");
    AST_IRQ_OFF: assert property (ien_q == 4'h0 && $past(ien_q) == 4'h0
        |-> !irq) else $error("irq with all sources off");
    AST_BAT_HOLD: assert property (battery_low_irq && !(reg_wr
        && reg_addr == hrw_pkg::ADDR_INT_CLR && reg_wdata[1])
        |=> battery_low_irq) else $error("battery flag dropped");
endmodule

bind hrw_top hrw_props hrw_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .proc_power_on(proc_power_on), .battery_low_irq(battery_low_irq));

// File: verification/hrw_partner.sv
`timescale 1ns/10ps
module hrw_partner (
    // clock
    input  wire logic sys_clk,
    // time base and wake side, idle low
    output logic      osc_tick = 1'b0,
    output logic      xtal_tick = 1'b0,
    output logic      wake_pin = 1'b0,
    output logic      battery_low = 1'b0
);
    // n slow ticks on one source, still between bursts
    task automatic ticks(input logic xtal, input int n);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge sys_clk);
            if (xtal)
                xtal_tick <= ~xtal_tick;
            else
                osc_tick <= ~osc_tick;
            repeat (3) @(posedge sys_clk);
        end
    endtask
    // wake pin and battery sense levels
    task automatic pins(input logic w, input logic b);
        @(posedge sys_clk);
        wake_pin    <= w;
        battery_low <= b;
    endtask
endmodule

// File: verification/hrw_top_test.sv
`timescale 1ns/10ps
module hrw_top_test;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        osc, xtal, wake, bat, pwr, bat_irq, irq;
    int          fail_count = 0;
    int          n_tests = 0;
    logic [7:0]  ta [4] = '{8'h04, 8'h05, 8'h40, 8'h7f};
    logic [31:0] td [4] = '{32'h1, 32'h9, 32'ha5a55a5a, 32'h0ff00ff0};
    always #4 sys_clk = ~sys_clk;
    hrw_top hrw_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .osc_tick(osc), .xtal_tick(xtal),
        .wake_pin(wake), .battery_low(bat), .proc_power_on(pwr),
        .battery_low_irq(bat_irq), .irq(irq));
    hrw_partner hrw_partner_i (.sys_clk(sys_clk), .osc_tick(osc),
        .xtal_tick(xtal), .wake_pin(wake), .battery_low(bat));
    task automatic chk(input string n, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 chk($sformatf("reg %h", a), reg_rdata, e);
    endtask
    task automatic pin(input string n, input int w, input logic e);
        logic s;
        repeat (w) @(posedge sys_clk);
        // sample the named output after the wait, not at call time
        #1 s = (n == "irq") ? irq : (n == "battery") ? bat_irq : pwr;
        chk(n, {31'h0, s}, {31'h0, e});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        stop_test;
    end
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        wr(8'h00, 32'h0);
        wr(8'h06, 32'h1234);
        rd(8'h06, 32'h7fff);
        wr(8'h00, 32'h3);
        rd(8'h00, 32'h3);
        foreach (ta[i]) wr(ta[i], td[i]);
        foreach (ta[i]) rd(ta[i], td[i]);
        rd(8'h30, 32'h0);
        $display("test registers done");
        wr(8'h00, 32'h1);
        wr(8'h03, 32'hfffffffe);
        wr(8'h01, 32'h0);
        hrw_partner_i.ticks(1'b0, 3);
        rd(8'h03, 32'h1);
        wr(8'h02, 32'h0);
        hrw_partner_i.ticks(1'b0, 2);
        rd(8'h03, 32'h1);
        wr(8'h01, 32'h0);
        wr(8'h00, 32'h3);
        repeat (16) @(posedge sys_clk);
        hrw_partner_i.ticks(1'b1, 128);
        rd(8'h03, 32'h2);
        $display("test counter done");
        wr(8'h00, 32'h1);
        wr(8'h07, 32'hf);
        rd(8'h07, 32'hf);
        wr(8'h04, 32'h4);
        wr(8'h05, 32'h5);
        hrw_partner_i.ticks(1'b0, 2);
        rd(8'h09, 32'h4);
        pin("irq", 0, 1'b1);
        hrw_partner_i.ticks(1'b0, 1);
        rd(8'h09, 32'hc);
        wr(8'h08, 32'hc);
        rd(8'h0a, 32'h0);
        pin("irq", 2, 1'b0);
        wr(8'h0b, 32'h0);
        rd(8'h09, 32'hc);
        wr(8'h0b, 32'hc);
        rd(8'h09, 32'h0);
        $display("test match done");
        hrw_partner_i.pins(1'b0, 1'b1);
        pin("battery", 6, 1'b1);
        wr(8'h00, 32'h15);
        wr(8'h0c, 32'h1);
        pin("power", 4, 1'b1);
        hrw_partner_i.pins(1'b0, 1'b0);
        wr(8'h0b, 32'h2);
        rd(8'h09, 32'h0);
        wr(8'h00, 32'h5);
        wr(8'h0c, 32'h1);
        pin("power", 4, 1'b0);
        hrw_partner_i.pins(1'b1, 1'b0);
        pin("power", 6, 1'b1);
        rd(8'h09, 32'h1);
        rd(8'h00, 32'h5);
        hrw_partner_i.pins(1'b0, 1'b0);
        wr(8'h0b, 32'h1);
        wr(8'h00, 32'h9);
        wr(8'h05, 32'h7);
        wr(8'h0c, 32'h1);
        pin("power", 4, 1'b0);
        hrw_partner_i.ticks(1'b0, 2);
        pin("power", 0, 1'b1);
        rd(8'h09, 32'h8);
        $display("test hibernate done");
        stop_test;
    end
endmodule
